// file: chg_defines.svh
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define CHG_ADDR_FAULT_FLAGS   8'h08
`define CHG_ADDR_CHARGER_FLAGS 8'h09
`define CHG_ADDR_BOOST_FLAGS   8'h0a
`define CHG_ADDR_PRIMARY_FAULT_MASK         8'h0b
`define CHG_ADDR_MASK2         8'h0c
`define CHG_ADDR_MASK3         8'h0d
`define CHG_ADDR_CFG           8'h11

// ************************************************************
// Reset values and implemented bits
// ************************************************************
`define CHG_RST_ZERO           8'h00
`define CHG_RST_CFG            8'h42
`define CHG_RST_FLOOR_MV       13'h1194
`define CHG_PRIMARY_FAULT_MASK_WR_BITS      8'hc3
`define CHG_FAULT_IMPL_BITS    8'hc1
`define CHG_CHARGER_IMPL_BITS  8'hbf
`define CHG_BOOST_IMPL_BITS    8'he8
`define CHG_REG_W              8

// ************************************************************
// Field positions
// ************************************************************
`define CHG_FLOOR_MSB          6
`define CHG_FLOOR_LSB          4
`define CHG_PRECHG_MSB         1
`define CHG_PRECHG_LSB         0
`define CHG_FLOOR_OFF_CODE     3'h7
`define CHG_BIT_THERMAL_SD     7
`define CHG_BIT_INPUT_OVP      6
`define CHG_BIT_BATT_MISSING   0
`define CHG_BIT_REVERSE        7
`define CHG_BIT_CHG_TIMER      2
`define CHG_BIT_THERMAL_LOOP   1
`define CHG_BIT_FLOOR_LOOP     0
`define CHG_BIT_BOOST_OVP      7
`define CHG_BIT_BOOST_OVL      6

// ************************************************************
// Analog setting scales
// ************************************************************
`define CHG_FLOOR_BASE_MV      13'h1004
`define CHG_FLOOR_STEP_MV      13'h0064
`define CHG_PRECHG_20_MA       7'h14
`define CHG_PRECHG_40_MA       7'h28
`define CHG_PRECHG_60_MA       7'h3c

`endif

// file: chg_pkg.sv
package chg_pkg;

  typedef struct packed
  {
    logic [7:0]  primary_fault_mask;
    logic [7:0]  mask2;
    logic [7:0]  mask3;
    logic [7:0]  cfg;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        irq_oe;
    logic [12:0] floor_mv;
    logic        floor_en;
    logic [6:0]  prechg_ma;
  } chg_state_t;

endpackage

// file: chg_flag_bank.sv
`include "chg_defines.svh"

// Sticky event flags, cleared by a read once their condition has gone
module chg_flag_bank #(
  parameter int          WIDTH = `CHG_REG_W,
  parameter logic [7:0]  IMPL  = `CHG_RST_ZERO
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // Events and read strobe
  input  wire logic [WIDTH-1:0] cond_i,
  input  wire logic             rd_clr_i,
  // Flags
  output logic      [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  if (WIDTH != `CHG_REG_W)
  begin : g_bad_width
    $error("chg_flag_bank: WIDTH must equal the register width");
  end

  // A live condition always sets, so an event in the read cycle is kept
  always_comb
  begin
    flag_next = flag_reg;
    if (rd_clr_i)
    begin
      flag_next = flag_reg & cond_i;
    end
    flag_next = (flag_next | cond_i) & IMPL[WIDTH-1:0];
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      flag_reg <= '0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign flags_o = flag_reg;

endmodule

// file: chg_event_regs.sv
`include "chg_defines.svh"

module chg_event_regs (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Register access port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // Fault conditions
  input  wire logic        thermal_shutdown_cond_i,
  input  wire logic        input_overvolt_cond_i,
  input  wire logic        battery_missing_cond_i,
  // Charger conditions
  input  wire logic        reverse_protect_cond_i,
  input  wire logic        battery_overvolt_cond_i,
  input  wire logic        charge_done_cond_i,
  input  wire logic        recharge_request_cond_i,
  input  wire logic        charge_timer_expired_cond_i,
  input  wire logic        thermal_loop_cond_i,
  input  wire logic        input_floor_loop_cond_i,
  // Boost conditions
  input  wire logic        boost_input_overvolt_cond_i,
  input  wire logic        boost_overload_cond_i,
  input  wire logic        boost_low_battery_cond_i,
  input  wire logic        boost_timer_expired_cond_i,
  // Settings to the analog loops
  output logic [2:0]       input_voltage_floor_select_o,
  output logic             input_floor_enable_o,
  output logic [12:0]      input_floor_mv_o,
  output logic [1:0]       precharge_current_select_o,
  output logic [6:0]       precharge_ma_o,
  // Open-drain interrupt, driven low while the enable is high
  output logic             irq_o,
  output logic             irq_oe_o
);

  chg_pkg::chg_state_t st_reg;
  chg_pkg::chg_state_t st_next;
  logic [7:0] fault_cond;
  logic [7:0] charger_cond;
  logic [7:0] boost_cond;
  logic [7:0] fault_flags;
  logic [7:0] charger_flags;
  logic [7:0] boost_flags;
  logic       rd_fault;
  logic       rd_charger;
  logic       rd_boost;
  logic       wr_hit;

  // ************************************************************
  // Decoders
  // ************************************************************
  function automatic logic [12:0] floor_mv(input logic [2:0] code);
    floor_mv = `CHG_FLOOR_BASE_MV + (`CHG_FLOOR_STEP_MV * {10'h000, code});
  endfunction

  function automatic logic [6:0] prechg_ma(input logic [1:0] code);
    unique case (code)
      2'h0:    prechg_ma = `CHG_PRECHG_20_MA;
      2'h1:    prechg_ma = `CHG_PRECHG_40_MA;
      default: prechg_ma = `CHG_PRECHG_60_MA;
    endcase
  endfunction

  function automatic logic addr_rd(input logic [7:0] a, input logic [7:0] target);
    addr_rd = reg_rd_i && (a == target);
  endfunction

  // ************************************************************
  // Event flag banks
  // ************************************************************
  assign fault_cond   = {thermal_shutdown_cond_i, input_overvolt_cond_i, 5'h00,
                         battery_missing_cond_i};
  assign charger_cond = {reverse_protect_cond_i, 1'b0, battery_overvolt_cond_i,
                         charge_done_cond_i, recharge_request_cond_i,
                         charge_timer_expired_cond_i, thermal_loop_cond_i,
                         input_floor_loop_cond_i};
  assign boost_cond   = {boost_input_overvolt_cond_i, boost_overload_cond_i,
                         boost_low_battery_cond_i, 1'b0, boost_timer_expired_cond_i,
                         3'h0};

  assign rd_fault   = addr_rd(reg_addr_i, `CHG_ADDR_FAULT_FLAGS);
  assign rd_charger = addr_rd(reg_addr_i, `CHG_ADDR_CHARGER_FLAGS);
  assign rd_boost   = addr_rd(reg_addr_i, `CHG_ADDR_BOOST_FLAGS);

  chg_flag_bank #(.WIDTH(`CHG_REG_W), .IMPL(`CHG_FAULT_IMPL_BITS)) u_fault (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .cond_i    (fault_cond),
    .rd_clr_i  (rd_fault),
    .flags_o   (fault_flags)
  );

  chg_flag_bank #(.WIDTH(`CHG_REG_W), .IMPL(`CHG_CHARGER_IMPL_BITS)) u_charger (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .cond_i    (charger_cond),
    .rd_clr_i  (rd_charger),
    .flags_o   (charger_flags)
  );

  chg_flag_bank #(.WIDTH(`CHG_REG_W), .IMPL(`CHG_BOOST_IMPL_BITS)) u_boost (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .cond_i    (boost_cond),
    .rd_clr_i  (rd_boost),
    .flags_o   (boost_flags)
  );

  // ************************************************************
  // Register file and interrupt
  // ************************************************************
  assign wr_hit = reg_wr_i;

  always_comb
  begin
    st_next        = st_reg;
    st_next.rvalid = reg_rd_i;
    st_next.rdata  = `CHG_RST_ZERO;
    if (wr_hit)
    begin
      unique case (reg_addr_i)
        `CHG_ADDR_PRIMARY_FAULT_MASK: st_next.primary_fault_mask = reg_wdata_i & `CHG_PRIMARY_FAULT_MASK_WR_BITS;
        `CHG_ADDR_MASK2: st_next.mask2 = reg_wdata_i;
        `CHG_ADDR_MASK3: st_next.mask3 = reg_wdata_i;
        `CHG_ADDR_CFG:   st_next.cfg   = reg_wdata_i;
        default:         st_next.cfg   = st_reg.cfg;
      endcase
    end
    if (reg_rd_i)
    begin
      // Flags are returned as they stood before the read clears them
      unique case (reg_addr_i)
        `CHG_ADDR_FAULT_FLAGS:   st_next.rdata = fault_flags;
        `CHG_ADDR_CHARGER_FLAGS: st_next.rdata = charger_flags;
        `CHG_ADDR_BOOST_FLAGS:   st_next.rdata = boost_flags;
        `CHG_ADDR_PRIMARY_FAULT_MASK:         st_next.rdata = st_reg.primary_fault_mask;
        `CHG_ADDR_MASK2:         st_next.rdata = st_reg.mask2;
        `CHG_ADDR_MASK3:         st_next.rdata = st_reg.mask3;
        `CHG_ADDR_CFG:           st_next.rdata = st_reg.cfg;
        default:                 st_next.rdata = `CHG_RST_ZERO;
      endcase
    end
    st_next.floor_en  = st_next.cfg[`CHG_FLOOR_MSB:`CHG_FLOOR_LSB]
                        != `CHG_FLOOR_OFF_CODE;
    st_next.floor_mv  = st_next.floor_en
                        ? floor_mv(st_next.cfg[`CHG_FLOOR_MSB:`CHG_FLOOR_LSB])
                        : 13'h0000;
    st_next.prechg_ma = prechg_ma(st_next.cfg[`CHG_PRECHG_MSB:`CHG_PRECHG_LSB]);
    // Mask 1 suppresses, 0 passes; bit positions line up with the flags
    st_next.irq_oe = |((fault_flags & ~st_reg.primary_fault_mask)
                     | (charger_flags & ~st_reg.mask2)
                     | (boost_flags & ~st_reg.mask3));
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_reg           <= '0;
      st_reg.cfg       <= `CHG_RST_CFG;
      st_reg.floor_en  <= 1'b1;
      st_reg.floor_mv  <= `CHG_RST_FLOOR_MV;
      st_reg.prechg_ma <= `CHG_PRECHG_60_MA;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o                  = st_reg.rdata;
  assign reg_rvalid_o                 = st_reg.rvalid;
  assign input_voltage_floor_select_o = st_reg.cfg[`CHG_FLOOR_MSB:`CHG_FLOOR_LSB];
  assign input_floor_enable_o         = st_reg.floor_en;
  assign input_floor_mv_o             = st_reg.floor_mv;
  assign precharge_current_select_o   = st_reg.cfg[`CHG_PRECHG_MSB:`CHG_PRECHG_LSB];
  assign precharge_ma_o               = st_reg.prechg_ma;
  assign irq_o                        = 1'b0;
  assign irq_oe_o                     = st_reg.irq_oe;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_flag_left_over;
    charger_flags[`CHG_BIT_REVERSE] && !reverse_protect_cond_i && !rd_charger;
  endsequence

  // Read of a set flag whose condition has already gone
  sequence s_read_clears;
    charger_flags[`CHG_BIT_REVERSE] && rd_charger && !reverse_protect_cond_i;
  endsequence

  a_reverse_sets: assert property (reverse_protect_cond_i |=> charger_flags[7])
    else $error("reverse protect flag not set");
  a_timer_sets: assert property (charge_timer_expired_cond_i |=> charger_flags[2])
    else $error("charge timer flag not set");
  a_thermal_loop: assert property (thermal_loop_cond_i |=> charger_flags[1])
    else $error("thermal loop flag not set");
  a_floor_loop: assert property (input_floor_loop_cond_i |=> charger_flags[0])
    else $error("input floor loop flag not set");
  a_floor_decode: assert property (
    input_floor_enable_o == (input_voltage_floor_select_o != 3'h7)
    && (!input_floor_enable_o || input_floor_mv_o == 13'd4100
        + 13'd100 * {10'h000, input_voltage_floor_select_o}))
    else $error("input floor decode wrong");
  a_prechg_decode: assert property (
    precharge_ma_o == ((precharge_current_select_o == 2'h0)
    ? 7'd20 : (precharge_current_select_o == 2'h1) ? 7'd40 : 7'd60))
    else $error("precharge decode wrong");
  a_boost_ovp_sets: assert property (boost_input_overvolt_cond_i |=> boost_flags[7])
    else $error("boost overvoltage flag not set");
  a_boost_ovl_sets: assert property (boost_overload_cond_i |=> boost_flags[6])
    else $error("boost overload flag not set");
  a_tsd_irq: assert property (fault_flags[7] && !st_reg.primary_fault_mask[7] |=> irq_oe_o)
    else $error("thermal shutdown irq missing");
  a_ovp_irq: assert property (fault_flags[6] && !st_reg.primary_fault_mask[6] |=> irq_oe_o)
    else $error("input overvoltage irq missing");
  a_batt_irq: assert property (fault_flags[0] && !st_reg.primary_fault_mask[0] |=> irq_oe_o)
    else $error("battery missing irq missing");
  a_masked_quiet: assert property (((fault_flags & ~st_reg.primary_fault_mask) == 8'h00)
    && ((charger_flags & ~st_reg.mask2) == 8'h00)
    && ((boost_flags & ~st_reg.mask3) == 8'h00) |=> !irq_oe_o)
    else $error("irq driven with all events masked");
  a_ovp_sets: assert property (input_overvolt_cond_i |=> fault_flags[6])
    else $error("input overvoltage flag not set");
  a_rev_irq: assert property (charger_flags[7] && !st_reg.mask2[7] |=> irq_oe_o)
    else $error("reverse protect irq missing");
  a_flag_holds: assert property (s_flag_left_over |=> charger_flags[7])
    else $error("flag dropped without a read");
  a_read_clears: assert property (s_read_clears |=> !charger_flags[`CHG_BIT_REVERSE])
    else $error("read did not clear stale flag");

endmodule

// file: chg_host_model.sv
// ************************************************************
// Host side of the open-drain interrupt line
// ************************************************************
module chg_host_model (
  // Interrupt pin from the device
  input  wire logic irq_i,
  input  wire logic irq_oe_i,
  // Resolved pin and host view
  output logic      irq_pin_o,
  output logic      irq_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // External pull-up holds the line high whenever the device lets go
  assign irq_pin_o  = irq_oe_i ? irq_i : 1'b1;
  assign irq_seen_o = ~irq_pin_o;
endmodule

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  addr      = 8'h00;
  logic [7:0]  wdata     = 8'h00;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [7:0]  fault_c   = 8'h00;
  logic [7:0]  chg_c     = 8'h00;
  logic [7:0]  bst_c     = 8'h00;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [2:0]  floor_sel;
  logic        floor_en;
  logic [12:0] floor_mv;
  logic [1:0]  pre_sel;
  logic [6:0]  pre_ma;
  logic        irq;
  logic        irq_oe;
  logic        irq_pin;
  logic        irq_seen;
  int          mismatches = 0;
  int          num_checks = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  chg_event_regs i_chg_event_regs (
    .clk_sys_i                    (clk_sys_i),
    .sys_rst_i                    (sys_rst_i),
    .reg_addr_i                   (addr),
    .reg_wr_i                     (wr),
    .reg_wdata_i                  (wdata),
    .reg_rd_i                     (rd),
    .reg_rdata_o                  (rdata),
    .reg_rvalid_o                 (rvalid),
    .thermal_shutdown_cond_i      (fault_c[7]),
    .input_overvolt_cond_i        (fault_c[6]),
    .battery_missing_cond_i       (fault_c[0]),
    .reverse_protect_cond_i       (chg_c[7]),
    .battery_overvolt_cond_i      (chg_c[5]),
    .charge_done_cond_i           (chg_c[4]),
    .recharge_request_cond_i      (chg_c[3]),
    .charge_timer_expired_cond_i  (chg_c[2]),
    .thermal_loop_cond_i          (chg_c[1]),
    .input_floor_loop_cond_i      (chg_c[0]),
    .boost_input_overvolt_cond_i  (bst_c[7]),
    .boost_overload_cond_i        (bst_c[6]),
    .boost_low_battery_cond_i     (bst_c[5]),
    .boost_timer_expired_cond_i   (bst_c[3]),
    .input_voltage_floor_select_o (floor_sel),
    .input_floor_enable_o         (floor_en),
    .input_floor_mv_o             (floor_mv),
    .precharge_current_select_o   (pre_sel),
    .precharge_ma_o               (pre_ma),
    .irq_o                        (irq),
    .irq_oe_o                     (irq_oe)
  );

  chg_host_model i_chg_host_model (
    .irq_i      (irq),
    .irq_oe_i   (irq_oe),
    .irq_pin_o  (irq_pin),
    .irq_seen_o (irq_seen)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Trailing idle cycle keeps strobes from being raised twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    tick;
    wr = 1'b0;
    tick;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    int n;
    addr = a;
    rd   = 1'b1;
    tick;
    rd = 1'b0;
    n  = 0;
    while (rvalid !== 1'b1 && n < 4)
    begin
      tick;
      n++;
    end
    if (rvalid !== 1'b1)
    begin
      mismatches++;
      $display("Error %s no read answer", name);
      tally_and_finish;
    end
    chk(name, {8'h00, exp}, {8'h00, rdata});
    tick;
  endtask

  // Pulse one condition, then expect the sticky flag and the pin
  task automatic ev(input logic [7:0] a, input int b, input logic irq_exp);
    case (a)
      8'h08: fault_c[b] = 1'b1;
      8'h09: chg_c[b] = 1'b1;
      default: bst_c[b] = 1'b1;
    endcase
    tick;
    fault_c = 8'h00;
    chg_c   = 8'h00;
    bst_c   = 8'h00;
    tick;
    chk("irq_seen", {15'h0000, irq_exp}, {15'h0000, irq_seen});
    rd_chk(a, 8'h01 << b, "flag_set");
    rd_chk(a, 8'h00, "flag_clr");
    chk("irq_released", 16'h0001, {15'h0000, irq_pin});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic sc_reset;
    rd_chk(8'h09, 8'h00, "chg_rst");
    rd_chk(8'h0a, 8'h00, "bst_rst");
    rd_chk(8'h0b, 8'h00, "primary_fault_mask_rst");
    rd_chk(8'h11, 8'h42, "cfg_rst");
    rd_chk(8'h3f, 8'h00, "unmapped");
    chk("floor_mv_rst", {3'h0, 13'h1194}, {3'h0, floor_mv});
    chk("pre_ma_rst", 16'h003c, {9'h000, pre_ma});
    wr_reg(8'h09, 8'hff);
    rd_chk(8'h09, 8'h00, "ro_write");
  endtask

  task automatic sc_cfg;
    logic [12:0] mv;
    logic [6:0]  ma;
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(8'h11, {1'b0, c[2:0], 2'b00, c[1:0]});
      rd_chk(8'h11, {1'b0, c[2:0], 2'b00, c[1:0]}, "cfg_back");
      mv = (c == 7) ? 13'h0000 : 13'h1004 + 13'h0064 * c[2:0];
      ma = (c[1:0] == 2'h0) ? 7'h14 : (c[1:0] == 2'h1) ? 7'h28 : 7'h3c;
      chk("floor_sel", {13'h0000, c[2:0]}, {13'h0000, floor_sel});
      chk("floor_en", {15'h0000, c != 7}, {15'h0000, floor_en});
      chk("floor_mv", {3'h0, mv}, {3'h0, floor_mv});
      chk("pre_sel", {14'h0000, c[1:0]}, {14'h0000, pre_sel});
      chk("pre_ma", {9'h000, ma}, {9'h000, pre_ma});
    end
  endtask

  task automatic sc_charger;
    ev(8'h09, 7, 1'b1);
    ev(8'h09, 2, 1'b1);
    ev(8'h09, 1, 1'b1);
    ev(8'h09, 0, 1'b1);
    wr_reg(8'h0c, 8'h80);
    ev(8'h09, 7, 1'b0);
    ev(8'h09, 2, 1'b1);
    wr_reg(8'h0c, 8'h00);
  endtask

  task automatic sc_boost;
    ev(8'h0a, 7, 1'b1);
    ev(8'h0a, 6, 1'b1);
  endtask

  task automatic sc_fault_mask;
    ev(8'h08, 7, 1'b1);
    ev(8'h08, 6, 1'b1);
    ev(8'h08, 0, 1'b1);
    wr_reg(8'h0b, 8'hff);
    rd_chk(8'h0b, 8'hc3, "primary_fault_mask_bits");
    ev(8'h08, 7, 1'b0);
    ev(8'h08, 6, 1'b0);
    ev(8'h08, 0, 1'b0);
    wr_reg(8'h0b, 8'h00);
  endtask

  initial
  begin
    repeat (5) tick;
    sys_rst_i = 1'b0;
    tick;
    sc_reset;
    sc_cfg;
    sc_charger;
    sc_boost;
    sc_fault_mask;
    tally_and_finish;
  end
endmodule
